/* hw/mii_pkg.sv */
// Purpose: shared constants and types of the mac-side media interface
// Assumes: core clock of 10 mhz; link clocks are sampled, not used as clocks
// Notes:   management frames are the usual 64-bit clause 22 layout
package mii_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // fastest management clock the phy accepts, as a period
  localparam int unsigned MDC_MIN_PERIOD_NS = 400;
  // half period in core cycles, least time so rounded up, at least one
  localparam int unsigned MDC_HALF_MIN =
    ((MDC_MIN_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // default half period, leaves room for the input synchroniser delay
  localparam int unsigned MDC_HALF_DEF = 4;

  // management frame layout, bit 63 goes out first
  localparam int unsigned FRAME_BITS = 64;
  localparam logic [5:0]  LAST_BIT   = 6'h3f;
  localparam logic [5:0]  TA_BIT     = 6'h2e;  // first turnaround bit
  localparam logic [5:0]  DATA_BIT   = 6'h30;  // first data bit
  localparam logic [31:0] PREAMBLE   = 32'hffffffff;
  localparam logic [1:0]  START_CODE = 2'h1;
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  TA_WRITE   = 2'h2;
  localparam logic [1:0]  TA_READ    = 2'h3;   // released, pull-up reads 1

  // one management request
  typedef struct packed {
    logic        rd;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } mii_mgmt_req_t;

  // one received octet with its framing
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       error;
  } mii_rx_beat_t;

endpackage

/* hw/mii_mgmt.sv */
// Purpose: management frame engine driving the clock and the data pin
// Assumes: mdio_i is already resynchronised to clk_i
// Notes:   data changes on the falling clock, is sampled on the rising one
module mii_mgmt
  import mii_pkg::*;
#(
  parameter int unsigned MDC_HALF = MDC_HALF_DEF
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // request side
  input  wire logic          start_i,
  input  wire mii_mgmt_req_t req_i,
  output logic               busy_o,
  output logic               done_o,
  output logic [15:0]        rdata_o,
  // pins
  output logic               mdc_o,
  input  wire logic          mdio_i,
  output logic               mdio_o,
  output logic               mdio_oe_o
);

  // refused at elaboration: the eight-bit divider and the fastest legal mdc
  if (MDC_HALF < MDC_HALF_MIN || MDC_HALF > 255) begin : g_half_bad
    $error("mii_mgmt: MDC_HALF out of range");
  end

  logic [7:0]  div_q;
  logic [5:0]  bit_q;
  logic [63:0] sr_q;
  logic        rd_q;
  logic        tick;

  assign tick = (div_q == 8'(MDC_HALF - 1));

  // whole frame built at once: preamble, start, op, addresses, ta, data
  function automatic logic [63:0] frame(input mii_mgmt_req_t r);
    frame = {PREAMBLE, START_CODE, r.rd ? OP_READ : OP_WRITE,
             r.phy_addr, r.reg_addr, r.rd ? TA_READ : TA_WRITE,
             r.rd ? 16'hffff : r.wdata};
  endfunction

  // half-period divider runs only while a frame is out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 8'h00;
    end else if (!busy_o || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // frame sequencing and pin drive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      mdc_o     <= 1'b0;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
      bit_q     <= 6'h00;
      sr_q      <= 64'h0;
      rd_q      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o) begin
        if (start_i) begin
          busy_o    <= 1'b1;
          sr_q      <= frame(req_i);
          rd_q      <= req_i.rd;
          bit_q     <= 6'h00;
          mdio_o    <= PREAMBLE[31];          // first bit on the wire
          mdio_oe_o <= 1'b1;
        end
      end else if (tick) begin
        mdc_o <= ~mdc_o;
        if (mdc_o) begin
          // falling edge: move to the next bit or finish
          if (bit_q == LAST_BIT) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b1;
            mdio_oe_o <= 1'b0;
          end else begin
            bit_q     <= bit_q + 6'h01;
            sr_q      <= {sr_q[62:0], 1'b0};
            mdio_o    <= sr_q[62];
            // release the pin from turnaround on for reads
            mdio_oe_o <= !(rd_q && (bit_q + 6'h01) >= TA_BIT);
          end
        end
      end
    end
  end

  // read data taken on rising edges of the data phase, msb first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (busy_o && tick && !mdc_o && rd_q && bit_q >= DATA_BIT) begin
      rdata_o <= {rdata_o[14:0], mdio_i};
    end
  end

endmodule

/* hw/mii_mac.sv */
// Purpose: mac side of the media independent interface toward a phy
// Assumes: link clocks are far slower than clk_i (at least 4x)
// Notes:   every pin input is resampled twice before use
//
// Behaviour
// - transmit enable high exactly while data lines carry a valid nibble
// - receive valid brackets the packet; sampled on rising receive clock
// - receive error of a single receive clock is caught
// - device drives management clock; drives and releases the data pin
// - link input active low when polarity input high, else active high
// - active-low phy reset output held low during our own reset
module mii_mac
  import mii_pkg::*;
#(
  parameter int unsigned MDC_HALF = MDC_HALF_DEF
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // transmit octets from the mac
  input  wire logic [7:0]    tx_data_i,
  input  wire logic          tx_valid_i,
  output logic               tx_ready_o,
  // received octets to the mac
  output mii_rx_beat_t       rx_beat_o,
  output logic               rx_valid_o,
  // management requests
  input  wire logic          mgmt_start_i,
  input  wire mii_mgmt_req_t mgmt_req_i,
  output logic               mgmt_busy_o,
  output logic               mgmt_done_o,
  output logic [15:0]        mgmt_rdata_o,
  // status
  output logic               link_up_o,
  output logic               collision_o,
  // phy transmit pins
  input  wire logic          txc_i,
  output logic [3:0]         txd_o,
  output logic               tx_en_o,
  // phy receive pins
  input  wire logic          rxc_i,
  input  wire logic [3:0]    rxd_i,
  input  wire logic          rx_dv_i,
  input  wire logic          rx_er_i,
  input  wire logic          collision_in_i,
  // phy management pins
  output logic               mdc_o,
  input  wire logic          mdio_i,
  output logic               mdio_o,
  output logic               mdio_oe_o,
  // link status pins and phy reset
  input  wire logic          link_in_i,
  input  wire logic          link_pol_i,
  output logic               phy_reset_n_o
);

  // two-stage synchroniser for every pin input
  localparam int unsigned SW = 12;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic          txc_s, rxc_s, dv_s, er_s, col_s, lnk_s, pol_s, mdio_s;
  logic [3:0]    rxd_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {txc_i, rxc_i, rxd_i, rx_dv_i, rx_er_i, collision_in_i,
               link_in_i, link_pol_i, mdio_i};
      s2_q <= s1_q;
    end
  end

  assign {txc_s, rxc_s, rxd_s, dv_s, er_s, col_s, lnk_s, pol_s, mdio_s} = s2_q;

  // previous samples, for edge detection and pre-edge values
  logic       txc_p_q, rxc_p_q, dv_p_q, er_p_q;
  logic [3:0] rxd_p_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txc_p_q <= 1'b0;
      rxc_p_q <= 1'b0;
      dv_p_q  <= 1'b0;
      er_p_q  <= 1'b0;
      rxd_p_q <= 4'h0;
    end else begin
      txc_p_q <= txc_s;
      rxc_p_q <= rxc_s;
      dv_p_q  <= dv_s;
      er_p_q  <= er_s;
      rxd_p_q <= rxd_s;
    end
  end

  logic tx_fall, rx_rise;
  assign tx_fall = txc_p_q & ~txc_s;
  assign rx_rise = ~rxc_p_q & rxc_s;

  // transmit: one octet held, its high nibble kept apart once started
  logic [7:0] hold_q;
  logic       have_q, have_d;
  logic [3:0] hi_q;
  logic       hi_pend_q;
  logic       accept;

  assign accept = tx_valid_i & tx_ready_o;

  // buffer frees at the low nibble so a new octet has a full txc period
  always_comb begin
    have_d = have_q;
    if (tx_fall && !hi_pend_q && have_q) begin
      have_d = 1'b0;
    end
    if (accept) begin
      have_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q     <= 8'h00;
      have_q     <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      have_q     <= have_d;
      tx_ready_o <= ~have_d;
      if (accept) begin
        hold_q <= tx_data_i;
      end
    end
  end

  // nibbles change on the falling txc so the phy sees them settled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_o     <= 4'h0;
      tx_en_o   <= 1'b0;
      hi_q      <= 4'h0;
      hi_pend_q <= 1'b0;
    end else if (tx_fall) begin
      if (hi_pend_q) begin
        txd_o     <= hi_q;
        tx_en_o   <= 1'b1;
        hi_pend_q <= 1'b0;
      end else if (have_q) begin
        txd_o     <= hold_q[3:0];
        tx_en_o   <= 1'b1;
        hi_q      <= hold_q[7:4];
        hi_pend_q <= 1'b1;
      end else begin
        txd_o     <= 4'h0;
        tx_en_o   <= 1'b0;
      end
    end
  end

  // receive: pre-edge samples are the values at the rising rxc
  logic [3:0] lo_q;
  logic       odd_q;
  logic       err_q;
  logic       in_pkt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_q       <= 4'h0;
      odd_q      <= 1'b0;
      err_q      <= 1'b0;
      in_pkt_q   <= 1'b0;
      rx_beat_o  <= '0;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (rx_rise) begin
        if (dv_p_q) begin
          in_pkt_q <= 1'b1;
          if (!odd_q) begin
            lo_q  <= rxd_p_q;
            odd_q <= 1'b1;
            err_q <= err_q | er_p_q;
          end else begin
            odd_q           <= 1'b0;
            err_q           <= err_q | er_p_q;
            rx_beat_o.data  <= {rxd_p_q, lo_q};
            rx_beat_o.last  <= 1'b0;
            rx_beat_o.error <= err_q | er_p_q;
            rx_valid_o      <= 1'b1;
          end
        end else if (in_pkt_q) begin
          // end of packet: a closing beat, odd nibble counts as error
          in_pkt_q        <= 1'b0;
          odd_q           <= 1'b0;
          err_q           <= 1'b0;
          rx_beat_o.data  <= 8'h00;
          rx_beat_o.last  <= 1'b1;
          rx_beat_o.error <= err_q | odd_q;
          rx_valid_o      <= 1'b1;
        end
      end
    end
  end

  // collision and link status, collision already synchronous to the phy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      collision_o <= 1'b0;
      link_up_o   <= 1'b0;
    end else begin
      collision_o <= col_s;
      link_up_o   <= pol_s ? ~lnk_s : lnk_s;
    end
  end

  // phy reset follows our own reset, released one edge later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_reset_n_o <= 1'b0;
    end else begin
      phy_reset_n_o <= 1'b1;
    end
  end

  // management engine
  mii_mgmt #(
    .MDC_HALF (MDC_HALF)
  ) u_mgmt (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (mgmt_start_i),
    .req_i     (mgmt_req_i),
    .busy_o    (mgmt_busy_o),
    .done_o    (mgmt_done_o),
    .rdata_o   (mgmt_rdata_o),
    .mdc_o     (mdc_o),
    .mdio_i    (mdio_s),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o)
  );

endmodule

/* bench/mii_mac_chk.sv */
// Purpose: port assertions for the mac side media interface
// Assumes: one core clock; pins resampled with about three clocks of lag
// Notes:   bound into every mii_mac instance
module mii_mac_chk #(
  parameter int unsigned MDC_HALF = 4
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // mac side
  input wire logic       tx_ready_o,
  input wire logic       rx_valid_o,
  input wire logic       mgmt_start_i,
  input wire logic       mgmt_busy_o,
  input wire logic       mgmt_done_o,
  // pins
  input wire logic [3:0] txd_o,
  input wire logic       tx_en_o,
  input wire logic       mdc_o,
  input wire logic       mdio_o,
  input wire logic       mdio_oe_o,
  input wire logic       link_in_i,
  input wire logic       link_pol_i,
  input wire logic       link_up_o,
  input wire logic       phy_reset_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // idle lines carry no stale nibble
  tx_idle_a: assert property (!tx_en_o |-> txd_o == 4'h0)
    else $error("txd not idle");
  // first nibble launch frees the octet buffer in the same edge
  tx_launch_a: assert property (
    $rose(tx_en_o) |-> tx_ready_o && !$past(tx_ready_o))
    else $error("tx launch without octet");
  rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("rx valid longer than one clock");
  // settled pins give the polarity corrected link after the resync
  link_pol_a: assert property (
    ($stable(link_in_i) && $stable(link_pol_i))[*5]
      |-> link_up_o == (link_pol_i ^ link_in_i))
    else $error("link status wrong");
  phy_rst_a: assert property (rst_n_i |-> ##1 phy_reset_n_o)
    else $error("phy reset not released");
  mgmt_go_a: assert property (
    mgmt_start_i && !mgmt_busy_o
      |=> mgmt_busy_o && mdio_oe_o && mdio_o && !mdc_o)
    else $error("frame did not start");
  mdc_half_a: assert property (
    $rose(mdc_o) |-> ##MDC_HALF $fell(mdc_o))
    else $error("mdc high time wrong");
  done_end_a: assert property (
    $fell(mgmt_busy_o) |-> mgmt_done_o && !mdio_oe_o && !mdc_o)
    else $error("frame end wrong");
endmodule

bind mii_mac mii_mac_chk #(.MDC_HALF(MDC_HALF)) mii_mac_chk_i (
  .clk_i, .rst_n_i, .tx_ready_o, .rx_valid_o, .mgmt_start_i, .mgmt_busy_o,
  .mgmt_done_o, .txd_o, .tx_en_o, .mdc_o, .mdio_o, .mdio_oe_o, .link_in_i,
  .link_pol_i, .link_up_o, .phy_reset_n_o);

/* bench/mii_phy.sv */
// Purpose: behavioural phy on the far side of the media interface
// Assumes: link clocks free running at 800 ns; mdio_i is the resolved wire
// Notes:   the bench sets col_o, rd_en, rd_val and n by hierarchy
module mii_phy (
  // link clocks and receive pins
  output logic            txc_o,
  output logic            rxc_o,
  output logic [3:0]      rxd_o,
  output logic            rx_dv_o,
  output logic            rx_er_o,
  output logic            col_o,
  // transmit pins and management pins
  input  wire logic [3:0] txd_i,
  input  wire logic       tx_en_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  tx_q[$];  // nibbles seen while enabled
  logic [63:0] frm;      // management bits, first one on top
  logic [15:0] rd_val;   // answer to read frames
  logic        rd_en;
  int          n;        // mdc rises since the bench cleared it

  // clocks with unrelated phases; idle receive pins
  initial begin
    txc_o = 1'b0;
    rxc_o = 1'b0;
    rxd_o = 4'h0;
    rx_dv_o = 1'b0;
    rx_er_o = 1'b0;
    col_o = 1'b0;
    mdio_oe_o = 1'b0;
    fork
      #130 forever #400 txc_o = ~txc_o;
      #370 forever #400 rxc_o = ~rxc_o;
    join
  end
  // mac launches after our fall, so the next fall sees it settled
  always @(negedge txc_o)
    if (tx_en_i === 1'b1)
      tx_q.push_back(txd_i);
  // one packet, low nibble first, bad marks a nibble with an error
  task automatic send(input logic [7:0] b[$], input int nibs, input int bad);
    for (int k = 0; k < nibs; k++) begin
      @(negedge rxc_o);
      rx_dv_o = 1'b1;
      rxd_o = k[0] ? b[k / 2][7:4] : b[k / 2][3:0];
      rx_er_o = (k == bad);
    end
    @(negedge rxc_o);
    rx_dv_o = 1'b0;
    rx_er_o = 1'b0;
    rxd_o = ~rxd_o;  // no stale data once the packet ends
  endtask
  // keep every bit on the wire
  always @(posedge mdc_i) begin
    n <= n + 1;
    frm <= {frm[62:0], mdio_i};
  end
  // reads: zero in the second turnaround bit, then data msb first
  always @(negedge mdc_i) begin
    mdio_oe_o <= rd_en && n >= 47 && n <= 63;
    mdio_o <= (n == 47) ? 1'b0 : rd_val[4'(63 - n)];
  end
endmodule

/* bench/tb_top.sv */
// Purpose: self-checking bench for the mac side media interface
// Assumes: phy model on the far side, mdio pulled up
// Notes:   random data from a fixed seed, corner cases mixed in
module tb_top
  import mii_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HALF = 4;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [7:0]    tx_data = 8'h00;
  logic          tx_valid = 1'b0;
  logic          start = 1'b0;
  logic          link_in = 1'b0;
  logic          link_pol = 1'b0;
  mii_mgmt_req_t mreq = '0;
  mii_rx_beat_t  beat;
  logic [15:0]   rdata;
  logic [3:0]    txd, rxd;
  logic          tx_ready, rx_valid, busy, done, link_up, col, txc, rxc;
  logic          tx_en, dv, er, col_in, mdc, mo, moe, po, poe, phy_rst_n;
  wire           mdio = moe ? mo : (poe ? po : 1'b1);  // pull-up
  int            num_errors = 0;
  int            check_count = 0;
  int            cycles = 0;
  mii_rx_beat_t  exp_q[$];

  mii_mac #(.MDC_HALF(HALF)) mii_mac_i (
    .clk_i(clk), .rst_n_i(rst_n), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_beat_o(beat),
    .rx_valid_o(rx_valid), .mgmt_start_i(start), .mgmt_req_i(mreq),
    .mgmt_busy_o(busy), .mgmt_done_o(done), .mgmt_rdata_o(rdata),
    .link_up_o(link_up), .collision_o(col), .txc_i(txc), .txd_o(txd),
    .tx_en_o(tx_en), .rxc_i(rxc), .rxd_i(rxd), .rx_dv_i(dv),
    .rx_er_i(er), .collision_in_i(col_in), .mdc_o(mdc), .mdio_i(mdio),
    .mdio_o(mo), .mdio_oe_o(moe), .link_in_i(link_in),
    .link_pol_i(link_pol), .phy_reset_n_o(phy_rst_n));
  mii_phy mii_phy_i (
    .txc_o(txc), .rxc_o(rxc), .rxd_o(rxd), .rx_dv_o(dv), .rx_er_o(er),
    .col_o(col_in), .txd_i(txd), .tx_en_i(tx_en), .mdc_i(mdc),
    .mdio_i(mdio), .mdio_o(po), .mdio_oe_o(poe));

  always #50 clk = ~clk;
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // whole run needs about 1500 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  // beats in order; an unexpected one compares against all ones
  always @(posedge clk)
    if (rx_valid === 1'b1)
      check(beat, exp_q.size() ? exp_q.pop_front() : '1);
  function automatic logic [63:0] frame(mii_mgmt_req_t r, logic [15:0] v);
    return {PREAMBLE, START_CODE, r.rd ? OP_READ : OP_WRITE, r.phy_addr,
      r.reg_addr, 2'h2, r.rd ? v : r.wdata};
  endfunction
  task automatic do_reset();
    rst_n = 1'b0;
    step(1);
    check({phy_rst_n, tx_ready, moe}, 0);
    step(1);
    rst_n = 1'b1;
    step(2);
    check(phy_rst_n, 1);
    $display("test reset done");
  endtask
  // hold the octet until an edge sees ready
  task automatic tx_byte(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1)
      @(posedge clk);
    #5;
  endtask
  // odd adds half an octet that must be dropped
  task automatic rx_pkt(input int len, input int bad, input bit odd);
    logic [7:0] b[$];
    bit         err;
    err = 1'b0;
    repeat (len + odd) b.push_back(8'($urandom));
    for (int i = 0; i < len; i++) begin
      err |= (bad >= 0 && bad / 2 <= i);
      exp_q.push_back('{b[i], 1'b0, err});
    end
    exp_q.push_back('{8'h00, 1'b1, err | odd});
    mii_phy_i.send(b, 2 * len + odd, bad);
    step(40);
  endtask
  // second start mid-frame must be ignored
  task automatic mgmt(input mii_mgmt_req_t r);
    mii_phy_i.n = 0;
    mii_phy_i.rd_en = r.rd;
    mreq = r;
    start = 1'b1;
    step(1);
    start = 1'b0;
    step(100);
    start = 1'b1;
    step(1);
    start = 1'b0;
    while (done !== 1'b1)
      @(posedge clk);
    #5;
    check(mii_phy_i.n, 64);
  endtask

  initial begin
    logic [7:0]    b[$];
    mii_mgmt_req_t r;
    void'($urandom(14));
    do_reset();
    for (int i = 0; i < 8; i++) begin
      b.push_back(i == 0 ? 8'h0f : 8'($urandom));
      tx_byte(b[i]);
    end
    tx_valid = 1'b0;
    step(60);
    check(mii_phy_i.tx_q.size(), 16);
    foreach (b[i])
      check({mii_phy_i.tx_q[2*i+1], mii_phy_i.tx_q[2*i]}, b[i]);
    $display("test transmit done");
    rx_pkt(4, -1, 1'b0);
    rx_pkt(3, 3, 1'b0);
    rx_pkt(2, -1, 1'b1);
    check(exp_q.size(), 0);
    $display("test receive done");
    for (int i = 0; i < 2; i++) begin
      r = 27'($urandom);
      r.rd = i[0];
      mii_phy_i.rd_val = 16'($urandom);
      mgmt(r);
      check(mii_phy_i.frm, frame(r, mii_phy_i.rd_val));
      if (r.rd)
        check(rdata, mii_phy_i.rd_val);
    end
    $display("test management done");
    for (int i = 0; i < 4; i++) begin
      {link_pol, link_in} = 2'(i);
      step(6);
      check(link_up, link_pol ? !link_in : link_in);
    end
    check(col, 0);
    mii_phy_i.col_o = 1'b1;
    step(6);
    check(col, 1);
    mii_phy_i.col_o = 1'b0;
    step(6);
    check(col, 0);
    $display("test status done");
    do_reset();
    give_verdict();
  end
endmodule
